// file: src/fps_panel.sv
`timescale 1ns/1ns
`default_nettype none
`include "fps_cfg.svh"
// Notes on behaviour
// - flash H on high voltage in math modes
// - warning flash never changes modes or values
// - store key shows question-mark prompt
// - bare terminator stores the shown reading
// - digits echoed, terminator commits entered number
// - back to reading, or limit result
// - recall prompt, value shown while key held
// - key release resumes, nothing changed
// - recall, high or low, YES, limits/peak
// - momentary error aborts, clears at trigger; one raised on a bad sequence or out-of-limit entry clears on a timer
// - latching error halts until function selected
// - error 0: bad zero or overrange entry
// - error 1: store during overload
// - error 6: display overflow
// - error 7: external reference above 20 V
// - error b: bad sequence in calibration
// - error C: bad sequence or value
// - error d: calibration memory missing or faulty
// - error F: calibration memory checksum
// - latching 9, or 3 for dc path
// - latching E: converter or memory conflict
// - error H ohms fault, 8 controller
module fps_panel
  import fps_pkg::*;
#(
  parameter int ERR_SHOW_CYC = `FPS_ERR_SHOW_MS * `FPS_CLK_MHZ * 1000,
  parameter int FLASH_CYC = `FPS_FLASH_MS * `FPS_CLK_MHZ * 1000
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // raw push buttons
  input wire logic [`FPS_NKEYS-1:0] key_pin,
  // measurement engine and trigger
  input wire logic trig,
  input wire logic overload,
  input wire logic disp_overflow,
  input wire logic entry_overrange,
  input wire logic entry_out_of_limit,
  input wire logic func_dcv_or_ohms,
  input wire logic math_mode_on,
  input wire logic hv_pin,
  input wire logic extref_over_20v,
  input wire logic ohms_conn_fault,
  input wire logic ctrl_fault,
  // module presence and calibration memory
  input wire logic cal_mode,
  input wire logic calmem_fault,
  input wire logic calmem_cksum_bad,
  input wire logic sel_module_bad,
  input wire logic sel_is_dcv,
  input wire logic ac_conv_conflict,
  // display
  output var fps_disp_e disp_sel,
  output logic [`FPS_DIGITS*4-1:0] entry_digits,
  output logic [`FPS_LEN_W-1:0] entry_len,
  output logic exp_h_flash,
  output logic func_ann_on,
  // mode commit and recall
  output logic commit,
  output fps_kidx_t commit_key,
  output logic commit_from_disp,
  output fps_kidx_t recall_key,
  output logic recall_hi,
  // errors
  output logic err_on,
  output logic err_latching,
  output logic [3:0] err_code,
  output logic abort_reading
);

  fps_key_if k ();

  fps_keys u_keys (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .key_pin(key_pin),
    .k(k)
  );

  function automatic fps_kidx_t first_key(input fps_keys_t p);
    fps_kidx_t r;
    r = '0;
    for (int i = `FPS_NKEYS - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = fps_kidx_t'(i);
      end
    end
    return r;
  endfunction : first_key

  fps_state_e state_reg;
  fps_kidx_t kidx;
  logic anyp;
  logic is_digit;
  logic store_term;
  logic recall_term;
  logic halted;
  logic show_limit_reg;
  logic timed_reg;
  logic [`FPS_TMR_W-1:0] tmr_reg;
  logic bad_seq;
  logic zero_bad;
  logic store_ovl;
  logic ovr_entry;
  logic lim_entry;
  logic mom_req;
  logic [3:0] mom_code;
  logic lat_req;
  logic [3:0] lat_code;
  logic func_ok;
  logic hv_s1_reg;
  logic hv_s2_reg;
  logic phase_reg;
  logic [`FPS_FLASH_W-1:0] flash_cnt_reg;
  fps_disp_e disp_next;

  assign halted = err_latching;
  assign func_ann_on = ~err_latching;
  assign anyp = |k.press;
  assign kidx = first_key(k.press);
  assign is_digit = kidx <= fps_kidx_t'(`FPS_K_DP);
  assign store_term = k.press[`FPS_K_FILTER] | k.press[`FPS_K_SAMPLE] | k.press[`FPS_K_SCALE]
                    | k.press[`FPS_K_HI] | k.press[`FPS_K_LO] | k.press[`FPS_K_OFFSET];
  assign recall_term = k.press[`FPS_K_OFFSET] | k.press[`FPS_K_SCALE] | k.press[`FPS_K_FILTER]
                     | k.press[`FPS_K_SAMPLE] | k.press[`FPS_K_ZERO];

  // sequence faults seen on a key press
  always_comb begin
    bad_seq = 1'b0;
    zero_bad = 1'b0;
    store_ovl = 1'b0;
    ovr_entry = 1'b0;
    lim_entry = 1'b0;
    if (!halted && anyp) begin
      unique case (state_reg)
        ST_IDLE: begin
          zero_bad = k.press[`FPS_K_ZERO] & ~func_dcv_or_ohms;
          store_ovl = k.press[`FPS_K_STORE] & overload;
        end
        ST_STORE: begin
          if (!is_digit && store_term) begin
            ovr_entry = (entry_len != `FPS_LEN_ZERO) & entry_overrange;
            lim_entry = (entry_len != `FPS_LEN_ZERO) & entry_out_of_limit;
          end else if (!is_digit) begin
            bad_seq = 1'b1;
          end
        end
        ST_RECALL: bad_seq = ~recall_term & ~k.press[`FPS_K_HI] & ~k.press[`FPS_K_LO];
        ST_YES: bad_seq = ~k.press[`FPS_K_LIMITS] & ~k.press[`FPS_K_PEAK];
        ST_SHOW: bad_seq = 1'b0;
        default: bad_seq = 1'b0;
      endcase
    end
  end

  // momentary sources, most severe first
  always_comb begin
    mom_req = 1'b1;
    mom_code = `FPS_ERR_0;
    if (ctrl_fault) begin
      mom_code = `FPS_ERR_8;
    end else if (calmem_fault) begin
      mom_code = `FPS_ERR_D;
    end else if (calmem_cksum_bad) begin
      mom_code = `FPS_ERR_F;
    end else if (ohms_conn_fault) begin
      mom_code = `FPS_ERR_H;
    end else if (extref_over_20v) begin
      mom_code = `FPS_ERR_7;
    end else if (disp_overflow) begin
      mom_code = `FPS_ERR_6;
    end else if (store_ovl) begin
      mom_code = `FPS_ERR_1;
    end else if (zero_bad || ovr_entry) begin
      mom_code = `FPS_ERR_0;
    end else if (bad_seq) begin
      mom_code = cal_mode ? `FPS_ERR_B : `FPS_ERR_C;
    end else if (lim_entry) begin
      mom_code = `FPS_ERR_C;
    end else begin
      mom_req = 1'b0;
    end
  end

  // latching sources
  always_comb begin
    lat_req = 1'b0;
    lat_code = `FPS_ERR_E;
    if (ac_conv_conflict) begin
      lat_req = 1'b1;
    end else if (k.press[`FPS_K_FUNC] && sel_module_bad) begin
      lat_req = 1'b1;
      lat_code = sel_is_dcv ? `FPS_ERR_3 : `FPS_ERR_9;
    end
  end
  assign func_ok = k.press[`FPS_K_FUNC] & ~sel_module_bad & ~ac_conv_conflict;

  // error register; errors raised with bad_seq or lim_entry time out, other momentary ones wait for a trigger, latching ones for a function key
  always_ff @(posedge clk) begin
    if (rst) begin
      err_on <= 1'b0;
      err_latching <= 1'b0;
      err_code <= `FPS_ERR_0;
      timed_reg <= 1'b0;
      tmr_reg <= '0;
      abort_reading <= 1'b0;
    end else if (ce) begin
      abort_reading <= 1'b0;
      tmr_reg <= tmr_reg + 1'b1;
      if (lat_req) begin
        err_on <= 1'b1;
        err_latching <= 1'b1;
        err_code <= lat_code;
      end else if (err_latching) begin
        if (func_ok) begin
          err_on <= 1'b0;
          err_latching <= 1'b0;
        end
      end else if (mom_req) begin
        err_on <= 1'b1;
        err_code <= mom_code;
        abort_reading <= 1'b1;
        timed_reg <= bad_seq | lim_entry;
        tmr_reg <= '0;
      end else if (err_on && (timed_reg ? tmr_reg == `FPS_TMR_W'(ERR_SHOW_CYC - 1) : trig)) begin
        err_on <= 1'b0;
      end
    end
  end

  // store and recall sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      entry_digits <= '0;
      entry_len <= `FPS_LEN_ZERO;
      commit <= 1'b0;
      commit_key <= '0;
      commit_from_disp <= 1'b0;
      recall_key <= '0;
      recall_hi <= 1'b0;
      show_limit_reg <= 1'b0;
    end else if (ce) begin
      commit <= 1'b0;
      if (halted) begin
        state_reg <= ST_IDLE;
      end else if (state_reg == ST_SHOW) begin
        if (!k.held[recall_key]) begin
          state_reg <= ST_IDLE;
        end
      end else if (anyp) begin
        unique case (state_reg)
          ST_IDLE: begin
            if (k.press[`FPS_K_STORE] && !overload) begin
              state_reg <= ST_STORE;
              entry_len <= `FPS_LEN_ZERO;
              entry_digits <= '0;
              show_limit_reg <= 1'b0;
            end else if (k.press[`FPS_K_RECALL]) begin
              state_reg <= ST_RECALL;
            end else if (k.press[`FPS_K_FUNC]) begin
              show_limit_reg <= 1'b0;
            end
          end
          ST_STORE: begin
            if (is_digit) begin
              if (entry_len != `FPS_LEN_FULL) begin
                entry_digits <= {entry_digits[`FPS_DIGITS*4-5:0], kidx[3:0]};
                entry_len <= entry_len + 1'b1;
              end
            end else begin
              state_reg <= ST_IDLE;
              if (store_term && !ovr_entry && !lim_entry) begin
                commit <= 1'b1;
                commit_key <= kidx;
                commit_from_disp <= entry_len == `FPS_LEN_ZERO;
                show_limit_reg <= k.press[`FPS_K_HI] | k.press[`FPS_K_LO];
              end
            end
          end
          ST_RECALL: begin
            if (recall_term) begin
              state_reg <= ST_SHOW;
              recall_key <= kidx;
            end else if (k.press[`FPS_K_HI] || k.press[`FPS_K_LO]) begin
              state_reg <= ST_YES;
              recall_hi <= k.press[`FPS_K_HI];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_YES: begin
            if (k.press[`FPS_K_LIMITS] || k.press[`FPS_K_PEAK]) begin
              state_reg <= ST_SHOW;
              recall_key <= kidx;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // display selection, registered; one cycle behind the state
  always_comb begin
    disp_next = DS_READING;
    if (err_on) begin
      disp_next = DS_ERROR;
    end else begin
      unique case (state_reg)
        ST_IDLE: disp_next = show_limit_reg ? DS_LIMIT : DS_READING;
        ST_STORE: disp_next = (entry_len == `FPS_LEN_ZERO) ? DS_PROMPT : DS_DIGITS;
        ST_RECALL: disp_next = DS_PROMPT;
        ST_YES: disp_next = DS_YES;
        ST_SHOW: disp_next = DS_VALUE;
        default: disp_next = DS_READING;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      disp_sel <= DS_READING;
    end else if (ce) begin
      disp_sel <= disp_next;
    end
  end

  // high-voltage warning; comparator is asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      hv_s1_reg <= 1'b0;
      hv_s2_reg <= 1'b0;
      flash_cnt_reg <= '0;
      phase_reg <= 1'b0;
      exp_h_flash <= 1'b0;
    end else if (ce) begin
      hv_s1_reg <= hv_pin;
      hv_s2_reg <= hv_s1_reg;
      if (flash_cnt_reg == `FPS_FLASH_W'(FLASH_CYC - 1)) begin
        flash_cnt_reg <= '0;
        phase_reg <= ~phase_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 1'b1;
      end
      // drives only the exponent field, nothing else reads it
      exp_h_flash <= math_mode_on & hv_s2_reg & phase_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_store_prompt;
    ce && !halted && state_reg == ST_IDLE && k.press[`FPS_K_STORE] && !overload
      |=> state_reg == ST_STORE && entry_len == `FPS_LEN_ZERO;
  endproperty
  a_store_prompt: assert property (p_store_prompt) else $error("store did not prompt");

  property p_store_ovl;
    ce && !halted && !lat_req && state_reg == ST_IDLE && k.press[`FPS_K_STORE] && overload
      |=> err_on && state_reg == ST_IDLE;
  endproperty
  a_store_ovl: assert property (p_store_ovl) else $error("store in overload not refused");

  property p_bare_term;
    ce && !halted && state_reg == ST_STORE && store_term && entry_len == `FPS_LEN_ZERO
      |=> commit && commit_from_disp && state_reg == ST_IDLE;
  endproperty
  a_bare_term: assert property (p_bare_term) else $error("bare terminator not committed");

  property p_num_term;
    ce && !halted && state_reg == ST_STORE && store_term && !is_digit && entry_len != `FPS_LEN_ZERO
      && !entry_overrange && !entry_out_of_limit |=> commit && !commit_from_disp;
  endproperty
  a_num_term: assert property (p_num_term) else $error("numeric entry not committed");

  property p_release;
    ce && !halted && state_reg == ST_SHOW && !k.held[recall_key] |=> state_reg == ST_IDLE && !commit;
  endproperty
  a_release: assert property (p_release) else $error("recall release did not resume");

  property p_yes;
    ce && !halted && state_reg == ST_RECALL && k.press[`FPS_K_HI] && !recall_term
      |=> state_reg == ST_YES && recall_hi;
  endproperty
  a_yes: assert property (p_yes) else $error("high key did not ask YES");

  property p_mom;
    ce && mom_req && !lat_req && !err_latching |=> err_on && func_ann_on && abort_reading ##1 !abort_reading;
  endproperty
  a_mom: assert property (p_mom) else $error("momentary error handling wrong");

  property p_lat_wins;
    ce && lat_req && mom_req |=> err_latching && !func_ann_on && !abort_reading;
  endproperty
  a_lat_wins: assert property (p_lat_wins) else $error("latching error did not win");

  property p_conflict;
    ce && ac_conv_conflict |=> err_latching && err_code == `FPS_ERR_E;
  endproperty
  a_conflict: assert property (p_conflict) else $error("converter conflict not latched as E");

  property p_hflash_off;
    ce && !math_mode_on |=> !exp_h_flash;
  endproperty
  a_hflash_off: assert property (p_hflash_off) else $error("H flashed outside math modes");

endmodule : fps_panel

`default_nettype wire

// file: src/fps_cfg.svh
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// key indices; 0..9 are the digit keys
`define FPS_NKEYS 24
`define FPS_K_DP 10
`define FPS_K_STORE 11
`define FPS_K_RECALL 12
`define FPS_K_FILTER 13
`define FPS_K_SAMPLE 14
`define FPS_K_SCALE 15
`define FPS_K_HI 16
`define FPS_K_LO 17
`define FPS_K_OFFSET 18
`define FPS_K_LIMITS 19
`define FPS_K_PEAK 20
`define FPS_K_ZERO 21
`define FPS_K_FUNC 22
`define FPS_K_EXTREF 23

// numeric entry buffer
`define FPS_DIGITS 8
`define FPS_LEN_W 4
`define FPS_LEN_ZERO 4'h0
`define FPS_LEN_FULL 4'h8

// error codes shown on the display; H has no hex digit, so it uses 4'ha
`define FPS_ERR_0 4'h0
`define FPS_ERR_1 4'h1
`define FPS_ERR_3 4'h3
`define FPS_ERR_6 4'h6
`define FPS_ERR_7 4'h7
`define FPS_ERR_8 4'h8
`define FPS_ERR_9 4'h9
`define FPS_ERR_H 4'ha
`define FPS_ERR_B 4'hb
`define FPS_ERR_C 4'hc
`define FPS_ERR_D 4'hd
`define FPS_ERR_E 4'he
`define FPS_ERR_F 4'hf

// timing
`define FPS_CLK_MHZ 100
`define FPS_ERR_SHOW_MS 2000
`define FPS_FLASH_MS 250
`define FPS_TMR_W 28
`define FPS_FLASH_W 25

`endif

// file: src/fps_pkg.sv
package fps_pkg;
`include "fps_cfg.svh"

  typedef logic [`FPS_NKEYS-1:0] fps_keys_t;
  typedef logic [4:0] fps_kidx_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STORE = 3'h1,
    ST_RECALL = 3'h2,
    ST_YES = 3'h3,
    ST_SHOW = 3'h4
  } fps_state_e;

  typedef enum logic [2:0] {
    DS_READING = 3'h0,
    DS_PROMPT = 3'h1,
    DS_DIGITS = 3'h2,
    DS_YES = 3'h3,
    DS_VALUE = 3'h4,
    DS_LIMIT = 3'h5,
    DS_ERROR = 3'h6
  } fps_disp_e;

endpackage : fps_pkg

// file: src/fps_key_if.sv
`timescale 1ns/1ns
`default_nettype none

interface fps_key_if;
  import fps_pkg::*;
  fps_keys_t held;
  fps_keys_t press;
  modport src (output held, press);
  modport snk (input held, press);
endinterface : fps_key_if

`default_nettype wire

// file: src/fps_keys.sv
`timescale 1ns/1ns
`default_nettype none
`include "fps_cfg.svh"

module fps_keys
  import fps_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // raw buttons
  input wire logic [`FPS_NKEYS-1:0] key_pin,
  // conditioned keys
  fps_key_if.src k
);

  fps_keys_t s1_reg;
  fps_keys_t s2_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else if (ce) begin
      s1_reg <= key_pin;
      s2_reg <= s1_reg;
    end
  end

  // press lines up with the rising edge of held
  always_ff @(posedge clk) begin
    if (rst) begin
      k.held <= '0;
      k.press <= '0;
    end else if (ce) begin
      k.held <= s2_reg;
      k.press <= s2_reg & ~k.held;
    end
  end

endmodule : fps_keys

`default_nettype wire

// file: tb/fps_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "fps_cfg.svh"

// operator side: push buttons; the display is watched by the bench itself
module fps_panel_model
  import fps_pkg::*;
(
  // clock
  input wire logic clk,
  // buttons toward the panel
  output logic [`FPS_NKEYS-1:0] key_pin
);
  // released buttons read low, as the contacts are pulled down
  initial key_pin = '0;

  // keys change only just after an edge; the order of a sequence is left to the caller
  task automatic down(input fps_kidx_t k);
    @(posedge clk);
    key_pin[k] <= 1'b1;
  endtask : down

  task automatic up(input fps_kidx_t k);
    @(posedge clk);
    key_pin[k] <= 1'b0;
  endtask : up
endmodule : fps_panel_model

`default_nettype wire

// file: tb/front_panel_store_recall_errors_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fps_cfg.svh"

module front_panel_store_recall_errors_tb_top;
  import fps_pkg::*;
  typedef struct {fps_kidx_t k; fps_disp_e d;} fps_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trig = 1'b0, overload = 1'b0, dcvo = 1'b1, math = 1'b0, hv = 1'b0, cal = 1'b0;
  logic bad_mod = 1'b0, is_dcv = 1'b0, conflict = 1'b0, ovr = 1'b0, lim = 1'b0;
  logic [5:0] src = 6'h00;
  wire logic [`FPS_NKEYS-1:0] key_pin;
  fps_disp_e disp_sel;
  logic [31:0] entry_digits;
  logic [3:0] entry_len, err_code;
  logic exp_h_flash, func_ann_on, commit, commit_from_disp, recall_hi, err_on, err_latching, abort_reading;
  fps_kidx_t commit_key, recall_key, c_key;
  logic c_disp;
  int bad_count = 0, checks = 0, c_n = 0, a_n = 0, n0, hi, lo;
  // momentary sources in priority order: controller, memory, checksum, ohms, ext ref, overflow
  logic [3:0] codes[6] = '{4'h8, 4'hd, 4'hf, 4'ha, 4'h7, 4'h6};
  fps_row_s rows[6] = '{'{5'(`FPS_K_FILTER), DS_READING}, '{5'(`FPS_K_SAMPLE), DS_READING},
    '{5'(`FPS_K_SCALE), DS_READING}, '{5'(`FPS_K_HI), DS_LIMIT}, '{5'(`FPS_K_LO), DS_LIMIT},
    '{5'(`FPS_K_OFFSET), DS_READING}};

  fps_panel_model model_u (.clk(clk), .key_pin(key_pin));

  // short timers keep the run brief; expectations use the same figures
  fps_panel #(.ERR_SHOW_CYC(20), .FLASH_CYC(4)) dut_u (
    .clk(clk), .rst(rst), .ce(1'b1), .key_pin(key_pin), .trig(trig), .overload(overload),
    .disp_overflow(src[5]), .entry_overrange(ovr), .entry_out_of_limit(lim),
    .func_dcv_or_ohms(dcvo), .math_mode_on(math), .hv_pin(hv), .extref_over_20v(src[4]),
    .ohms_conn_fault(src[3]), .ctrl_fault(src[0]), .cal_mode(cal), .calmem_fault(src[1]),
    .calmem_cksum_bad(src[2]), .sel_module_bad(bad_mod), .sel_is_dcv(is_dcv),
    .ac_conv_conflict(conflict), .disp_sel(disp_sel), .entry_digits(entry_digits),
    .entry_len(entry_len), .exp_h_flash(exp_h_flash), .func_ann_on(func_ann_on), .commit(commit),
    .commit_key(commit_key), .commit_from_disp(commit_from_disp), .recall_key(recall_key),
    .recall_hi(recall_hi), .err_on(err_on), .err_latching(err_latching), .err_code(err_code),
    .abort_reading(abort_reading));

  initial begin
    forever #5 clk = ~clk;
  end

  // one-cycle pulses are caught here so they can be checked later
  always @(posedge clk) begin
    if (commit === 1'b1) begin
      c_key <= commit_key;
      c_disp <= commit_from_disp;
      c_n <= c_n + 1;
    end
    if (abort_reading === 1'b1) a_n <= a_n + 1;
  end

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_disp(input fps_disp_e e);
    checks++;
    if (disp_sel !== e) begin
      bad_count++;
      $display("unexpected disp_sel expected %0d seen %0d", e, disp_sel);
    end
  endtask : chk_disp

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic tap(input fps_kidx_t k);
    model_u.down(k);
    cyc(6);
    model_u.up(k);
    cyc(6);
  endtask : tap

  task automatic chk_err(input logic [3:0] code, input logic latch);
    chk_val("err_on", 1, err_on);
    chk_val("err_code", code, err_code);
    chk_val("err_latching", latch, err_latching);
    chk_val("func_ann_on", !latch, func_ann_on);
  endtask : chk_err

  task automatic pulse_trig;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    cyc(2);
  endtask : pulse_trig

  task complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // whole sequence needs several hundred cycles
  initial begin
    #200000;
    bad_count++;
    complete_run;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk_disp(DS_READING);
    chk_val("func_ann_on", 1, func_ann_on);
    chk_val("err_on", 0, err_on);
    foreach (rows[i]) begin
      n0 = c_n;
      tap(5'(`FPS_K_STORE));
      chk_disp(DS_PROMPT);
      tap(rows[i].k);
      chk_val("commits", n0 + 1, c_n);
      chk_val("commit_key", rows[i].k, c_key);
      chk_val("commit_from_disp", 1, c_disp);
      chk_disp(rows[i].d);
    end
    tap(5'(`FPS_K_STORE));
    tap(5'd1);
    tap(5'd2);
    chk_val("entry_len", 2, entry_len);
    chk_val("entry_digits", 8'h12, entry_digits[7:0]);
    chk_disp(DS_DIGITS);
    tap(5'(`FPS_K_OFFSET));
    chk_val("commit_key", `FPS_K_OFFSET, c_key);
    chk_val("commit_from_disp", 0, c_disp);
    chk_disp(DS_READING);
    // recall: value only while the key is held, nothing committed
    n0 = c_n;
    tap(5'(`FPS_K_RECALL));
    chk_disp(DS_PROMPT);
    model_u.down(5'(`FPS_K_SCALE));
    cyc(6);
    chk_disp(DS_VALUE);
    chk_val("recall_key", `FPS_K_SCALE, recall_key);
    model_u.up(5'(`FPS_K_SCALE));
    cyc(6);
    chk_disp(DS_READING);
    chk_val("commits", n0, c_n);
    tap(5'(`FPS_K_RECALL));
    tap(5'(`FPS_K_HI));
    chk_disp(DS_YES);
    model_u.down(5'(`FPS_K_LIMITS));
    cyc(6);
    chk_disp(DS_VALUE);
    chk_val("recall_key", `FPS_K_LIMITS, recall_key);
    chk_val("recall_hi", 1, recall_hi);
    model_u.up(5'(`FPS_K_LIMITS));
    cyc(6);
    chk_disp(DS_READING);
    for (int i = 0; i < 6; i++) begin
      n0 = a_n;
      @(posedge clk);
      src[i] <= 1'b1;
      @(posedge clk);
      src[i] <= 1'b0;
      cyc(2);
      chk_err(codes[i], 0);
      chk_val("aborts", n0 + 1, a_n);
      pulse_trig;
      chk_val("err_on", 0, err_on);
    end
    @(posedge clk);
    overload <= 1'b1;
    tap(5'(`FPS_K_STORE));
    chk_err(4'h1, 0);
    @(posedge clk);
    overload <= 1'b0;
    pulse_trig;
    @(posedge clk);
    dcvo <= 1'b0;
    tap(5'(`FPS_K_ZERO));
    chk_err(4'h0, 0);
    @(posedge clk);
    dcvo <= 1'b1;
    pulse_trig;
    // entered numbers out of range or limits are refused, nothing committed
    for (int j = 0; j < 2; j++) begin
      n0 = c_n;
      tap(5'(`FPS_K_STORE));
      tap(5'd5);
      @(posedge clk);
      ovr <= (j == 0);
      lim <= (j == 1);
      tap(5'(`FPS_K_OFFSET));
      chk_err(j ? 4'hc : 4'h0, 0);
      chk_val("commits", n0, c_n);
      @(posedge clk);
      ovr <= 1'b0;
      lim <= 1'b0;
      pulse_trig;
      cyc(12);
      chk_val("err_on", 0, err_on);
    end
    // bad sequence errors ignore the trigger and clear on their own timer
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      cal <= 1'(j);
      tap(5'(`FPS_K_STORE));
      tap(5'(`FPS_K_PEAK));
      chk_err(j ? 4'hb : 4'hc, 0);
      pulse_trig;
      chk_val("err_on", 1, err_on);
      cyc(12);
      chk_val("err_on", 0, err_on);
    end
    @(posedge clk);
    cal <= 1'b0;
    bad_mod <= 1'b1;
    tap(5'(`FPS_K_FUNC));
    chk_err(4'h9, 1);
    @(posedge clk);
    src[0] <= 1'b1;
    @(posedge clk);
    src[0] <= 1'b0;
    cyc(2);
    chk_err(4'h9, 1);
    pulse_trig;
    chk_val("err_on", 1, err_on);
    @(posedge clk);
    bad_mod <= 1'b0;
    tap(5'(`FPS_K_FUNC));
    chk_val("err_on", 0, err_on);
    @(posedge clk);
    bad_mod <= 1'b1;
    is_dcv <= 1'b1;
    tap(5'(`FPS_K_FUNC));
    chk_err(4'h3, 1);
    @(posedge clk);
    bad_mod <= 1'b0;
    is_dcv <= 1'b0;
    tap(5'(`FPS_K_FUNC));
    @(posedge clk);
    conflict <= 1'b1;
    src[5] <= 1'b1;
    cyc(3);
    chk_err(4'he, 1);
    @(posedge clk);
    conflict <= 1'b0;
    src[5] <= 1'b0;
    tap(5'(`FPS_K_FUNC));
    chk_val("func_ann_on", 1, func_ann_on);
    // high voltage flashes only while a math mode is on, and changes nothing
    @(posedge clk);
    hv <= 1'b1;
    cyc(10);
    chk_val("exp_h_flash", 0, exp_h_flash);
    n0 = c_n;
    hi = 0;
    lo = 0;
    @(posedge clk);
    math <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      cyc(1);
      if (exp_h_flash === 1'b1) hi++;
      else if (exp_h_flash === 1'b0) lo++;
    end
    chk_val("flash_toggles", 1, (hi > 3 && lo > 3));
    chk_val("err_on", 0, err_on);
    chk_val("commits", n0, c_n);
    chk_disp(DS_READING);
    @(posedge clk);
    hv <= 1'b0;
    cyc(10);
    chk_val("exp_h_flash", 0, exp_h_flash);
    @(posedge clk);
    math <= 1'b0;
    cyc(10);
    chk_val("exp_h_flash", 0, exp_h_flash);
    complete_run;
  end
endmodule : front_panel_store_recall_errors_tb_top

`default_nettype wire
